/* File: hw/fdc_command_decoder.sv */
// drive command word decoder and 16-bit reference/actual objects
//
// Notes on behaviour
// - references written at 2052h and 2053h are scaled by the scale setting
// - actual values read at 2055h and 2056h, scaled by the same setting
// - command word written at 2001h is forwarded unchanged to drive logic
// - bit 0 set requests a stop in configured or requested mode
// - bit 2 set reverses motor rotation
// - rising edge of bit 4 clears an active fault
// - bit 5 picks external location b, else a, when location is bus-chosen
// - with run enable from bus, bit 6 high disables run, low enables
// - bits 7, 8, 9 pick normal, emergency, freewheel; none gives configured mode
// - bit 11 forces ramp generator output to zero
// - bit 12 freezes ramp generator output
// - bit 13 forces ramp generator input to zero
// - bit 16 grants the bus local control
// - bit 17 takes the reference from the bus in local mode
// - bits 22 to 25 stored as user control bits
`timescale 1ns/10ps
module fdc_command_decoder
   import fdc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // object dictionary access from the bus master
   input wire logic objWrite,
   input wire logic objRead,
   input wire logic [fdc_pkg::INDEX_W-1:0] objIndex,
   input wire logic [fdc_pkg::WORD_W-1:0] objWrData,
   output logic [fdc_pkg::WORD_W-1:0] objRdData,
   output logic objRdValid,
   output logic objError,
   // configuration from drive parameters
   input wire logic [fdc_pkg::SCALE_W-1:0] cfgScale,
   input wire fdc_pkg::fdc_stop_mode_e cfgStopMode,
   input wire logic cfgLocationFromBus,
   input wire logic cfgRunEnableFromBus,
   input wire logic otherLocationB,
   input wire logic otherRunEnable,
   // drive state
   input wire logic faultActive,
   input wire logic signed [fdc_pkg::WORD_W-1:0] actualOne,
   input wire logic signed [fdc_pkg::WORD_W-1:0] actualTwo,
   // drive control outputs
   output logic [fdc_pkg::WORD_W-1:0] commandWord,
   output logic stopRequest,
   output fdc_pkg::fdc_stop_mode_e stopMode,
   output logic startRequest,
   output logic reverseRequest,
   output logic faultResetPulse,
   output logic externalLocationB,
   output logic runEnable,
   output logic rampOutZero,
   output logic rampHold,
   output logic rampInZero,
   output logic busTakeControl,
   output logic busTakeReference,
   output logic [fdc_pkg::USER_W-1:0] userBits,
   output logic signed [fdc_pkg::WORD_W-1:0] referenceOne,
   output logic signed [fdc_pkg::WORD_W-1:0] referenceTwo
);
   import fdc_pkg::*;

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   logic wrCommand;
   logic wrRefOne;
   logic wrRefTwo;
   logic rdActOne;
   logic rdActTwo;
   logic badAccess;

   assign wrCommand = objWrite && (objIndex == IDX_COMMAND_WORD);
   assign wrRefOne = objWrite && (objIndex == IDX_SHORT_REF_ONE);
   assign wrRefTwo = objWrite && (objIndex == IDX_SHORT_REF_TWO);
   assign rdActOne = objRead && (objIndex == IDX_SHORT_ACT_ONE);
   assign rdActTwo = objRead && (objIndex == IDX_SHORT_ACT_TWO);
   // writes to read-only objects and reads of write-only ones are refused
   assign badAccess = (objWrite && !(wrCommand || wrRefOne || wrRefTwo))
                      || (objRead && !(rdActOne || rdActTwo));

   // ----------------------------------------------------------------
   // command word store
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] cmd_ff;
   logic [WORD_W-1:0] nxt_cmd;

   assign nxt_cmd = wrCommand ? objWrData : cmd_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         cmd_ff <= CMD_WORD_RESET;
      end else begin
         cmd_ff <= nxt_cmd;
      end
   end

   // word is passed on bit for bit, reserved bits included
   always_ff @(posedge clk) begin
      if (srst) begin
         commandWord <= CMD_WORD_RESET;
      end else begin
         commandWord <= nxt_cmd;
      end
   end

   // ----------------------------------------------------------------
   // run and direction decode
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         stopRequest <= 1'b0;
      end else begin
         stopRequest <= nxt_cmd[CMD_STOP];
      end
   end

   // a word with both bits set must never start the motor
   always_ff @(posedge clk) begin
      if (srst) begin
         startRequest <= 1'b0;
      end else begin
         startRequest <= nxt_cmd[CMD_START] && !nxt_cmd[CMD_STOP];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reverseRequest <= 1'b0;
      end else begin
         reverseRequest <= nxt_cmd[CMD_REVERSE];
      end
   end

   // ----------------------------------------------------------------
   // stop mode selection
   // ----------------------------------------------------------------
   fdc_stop_mode_e nxtStopMode;

   // several request bits at once: the harder stop is taken
   always_comb begin
      nxtStopMode = cfgStopMode;
      if (nxt_cmd[CMD_FREEWHEEL_STOP]) begin
         nxtStopMode = STOP_FREEWHEEL;
      end else if (nxt_cmd[CMD_EMERGENCY_DECEL_STOP]) begin
         nxtStopMode = STOP_EMERGENCY_DECEL;
      end else if (nxt_cmd[CMD_NORMAL_DECEL_STOP]) begin
         nxtStopMode = STOP_NORMAL_DECEL;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         stopMode <= STOP_NORMAL_DECEL;
      end else begin
         stopMode <= nxtStopMode;
      end
   end

   // ----------------------------------------------------------------
   // fault reset on rising edge
   // ----------------------------------------------------------------
   // edge is seen against the stored word, so a rewrite of 1 does nothing
   always_ff @(posedge clk) begin
      if (srst) begin
         faultResetPulse <= 1'b0;
      end else begin
         faultResetPulse <= nxt_cmd[CMD_FAULT_RESET] && !cmd_ff[CMD_FAULT_RESET]
                            && faultActive;
      end
   end

   // ----------------------------------------------------------------
   // location and run enable
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         externalLocationB <= 1'b0;
      end else begin
         externalLocationB <= cfgLocationFromBus ? nxt_cmd[CMD_EXTERNAL_LOCATION_B]
                              : otherLocationB;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         runEnable <= 1'b0;
      end else begin
         runEnable <= cfgRunEnableFromBus ? !nxt_cmd[CMD_RUN_DISABLE]
                      : otherRunEnable;
      end
   end

   // ----------------------------------------------------------------
   // ramp generator forcing
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         rampOutZero <= 1'b0;
      end else begin
         rampOutZero <= nxt_cmd[CMD_RAMP_OUT_ZERO];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rampHold <= 1'b0;
      end else begin
         rampHold <= nxt_cmd[CMD_RAMP_HOLD];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rampInZero <= 1'b0;
      end else begin
         rampInZero <= nxt_cmd[CMD_RAMP_IN_ZERO];
      end
   end

   // ----------------------------------------------------------------
   // local control, reference stealing, user bits
   // ----------------------------------------------------------------
   // bits 3, 10, 14, 15, 18-21 and 26-31 feed no output here except commandWord
   always_ff @(posedge clk) begin
      if (srst) begin
         busTakeControl <= 1'b0;
      end else begin
         busTakeControl <= nxt_cmd[CMD_BUS_TAKE_CONTROL];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         busTakeReference <= 1'b0;
      end else begin
         busTakeReference <= nxt_cmd[CMD_BUS_TAKE_REFERENCE];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         userBits <= '0;
      end else begin
         userBits <= nxt_cmd[CMD_USER_MSB:CMD_USER_LSB];
      end
   end

   // ----------------------------------------------------------------
   // scaled references
   // ----------------------------------------------------------------
   logic signed [SHORT_W-1:0] refOne_ff;
   logic signed [SHORT_W-1:0] refTwo_ff;
   logic signed [SCALE_W:0] scaleSigned;
   logic signed [SHORT_W+SCALE_W:0] refOneProd;
   logic signed [SHORT_W+SCALE_W:0] refTwoProd;
   logic signed [SHORT_W+SCALE_W:0] refOneShift;
   logic signed [SHORT_W+SCALE_W:0] refTwoShift;

   always_ff @(posedge clk) begin
      if (srst) begin
         refOne_ff <= SHORT_RESET;
      end else if (wrRefOne) begin
         refOne_ff <= objWrData[SHORT_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         refTwo_ff <= SHORT_RESET;
      end else if (wrRefTwo) begin
         refTwo_ff <= objWrData[SHORT_W-1:0];
      end
   end

   assign scaleSigned = {1'b0, cfgScale};
   assign refOneProd = refOne_ff * scaleSigned;
   assign refTwoProd = refTwo_ff * scaleSigned;
   assign refOneShift = refOneProd >>> SCALE_FRAC;
   assign refTwoShift = refTwoProd >>> SCALE_FRAC;

   // scaling follows the setting live; one cycle behind the stored value
   always_ff @(posedge clk) begin
      if (srst) begin
         referenceOne <= '0;
      end else begin
         referenceOne <= refOneShift[WORD_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         referenceTwo <= '0;
      end else begin
         referenceTwo <= refTwoShift[WORD_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // scaled actual values and read answer
   // ----------------------------------------------------------------
   logic signed [WORD_W+SCALE_W:0] actOneProd;
   logic signed [WORD_W+SCALE_W:0] actTwoProd;
   logic signed [WORD_W+SCALE_W:0] actOneShift;
   logic signed [WORD_W+SCALE_W:0] actTwoShift;
   logic [WORD_W-1:0] nxtRdData;

   assign actOneProd = actualOne * scaleSigned;
   assign actTwoProd = actualTwo * scaleSigned;
   assign actOneShift = actOneProd >>> SCALE_FRAC;
   assign actTwoShift = actTwoProd >>> SCALE_FRAC;

   // truncated to 16 bits; large actuals wrap rather than saturate
   always_comb begin
      nxtRdData = '0;
      if (rdActOne) begin
         nxtRdData = {{(WORD_W-SHORT_W){1'b0}}, actOneShift[SHORT_W-1:0]};
      end else if (rdActTwo) begin
         nxtRdData = {{(WORD_W-SHORT_W){1'b0}}, actTwoShift[SHORT_W-1:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         objRdData <= '0;
      end else begin
         objRdData <= nxtRdData;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         objRdValid <= 1'b0;
      end else begin
         objRdValid <= rdActOne || rdActTwo;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         objError <= 1'b0;
      end else begin
         objError <= badAccess;
      end
   end

endmodule

/* File: hw/fdc_pkg.sv */
// constants and types shared by the drive command decoder
package fdc_pkg;

   // ----------------------------------------------------------------
   // object dictionary indices
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_COMMAND_WORD = 16'h2001;
   localparam logic [15:0] IDX_SHORT_REF_ONE = 16'h2052;
   localparam logic [15:0] IDX_SHORT_REF_TWO = 16'h2053;
   localparam logic [15:0] IDX_SHORT_ACT_ONE = 16'h2055;
   localparam logic [15:0] IDX_SHORT_ACT_TWO = 16'h2056;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int INDEX_W = 16;
   localparam int WORD_W = 32;
   localparam int SHORT_W = 16;
   localparam int SCALE_W = 16;
   localparam int USER_W = 4;

   // ----------------------------------------------------------------
   // command word bit positions
   // ----------------------------------------------------------------
   localparam int CMD_STOP = 0;
   localparam int CMD_START = 1;
   localparam int CMD_REVERSE = 2;
   localparam int CMD_FAULT_RESET = 4;
   localparam int CMD_EXTERNAL_LOCATION_B = 5;
   localparam int CMD_RUN_DISABLE = 6;
   localparam int CMD_NORMAL_DECEL_STOP = 7;
   localparam int CMD_EMERGENCY_DECEL_STOP = 8;
   localparam int CMD_FREEWHEEL_STOP = 9;
   localparam int CMD_RAMP_OUT_ZERO = 11;
   localparam int CMD_RAMP_HOLD = 12;
   localparam int CMD_RAMP_IN_ZERO = 13;
   localparam int CMD_BUS_TAKE_CONTROL = 16;
   localparam int CMD_BUS_TAKE_REFERENCE = 17;
   localparam int CMD_USER_LSB = 22;
   localparam int CMD_USER_MSB = 25;

   // ----------------------------------------------------------------
   // reset values and scaling
   // ----------------------------------------------------------------
   localparam logic [31:0] CMD_WORD_RESET = 32'h0000_0000;
   localparam logic [15:0] SHORT_RESET = 16'h0000;
   // scale setting is unsigned with this many fraction bits
   localparam int SCALE_FRAC = 8;

   // ----------------------------------------------------------------
   // stop modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      STOP_NORMAL_DECEL,
      STOP_EMERGENCY_DECEL,
      STOP_FREEWHEEL
   } fdc_stop_mode_e;

endpackage

/* File: testbench/fdc_command_decoder_sva.sv */
// assertion checker for the drive command decoder
`timescale 1ns/10ps
module fdc_command_decoder_sva
   import fdc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // object access
   input wire logic objWrite,
   input wire logic objRead,
   input wire logic [fdc_pkg::INDEX_W-1:0] objIndex,
   input wire logic [fdc_pkg::WORD_W-1:0] objWrData,
   input wire logic [fdc_pkg::WORD_W-1:0] objRdData,
   input wire logic objRdValid,
   input wire logic objError,
   // configuration and state
   input wire logic cfgLocationFromBus,
   input wire logic cfgRunEnableFromBus,
   input wire fdc_pkg::fdc_stop_mode_e cfgStopMode,
   input wire logic faultActive,
   // decoded outputs
   input wire logic [fdc_pkg::WORD_W-1:0] commandWord,
   input wire logic stopRequest,
   input wire fdc_pkg::fdc_stop_mode_e stopMode,
   input wire logic startRequest,
   input wire logic reverseRequest,
   input wire logic faultResetPulse,
   input wire logic externalLocationB,
   input wire logic runEnable,
   input wire logic rampOutZero,
   input wire logic rampHold,
   input wire logic rampInZero,
   input wire logic busTakeControl,
   input wire logic busTakeReference,
   input wire logic [fdc_pkg::USER_W-1:0] userBits
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic cmdWr;
   logic actRd;
   assign cmdWr = objWrite && objIndex == IDX_COMMAND_WORD;
   assign actRd = objRead && !objWrite && (objIndex == IDX_SHORT_ACT_ONE || objIndex == IDX_SHORT_ACT_TWO);
   AST_FORWARD: assert property (cmdWr |=> commandWord == $past(objWrData))
      else $error("command word not forwarded");
   AST_START: assert property (stopRequest == commandWord[0] &&
      startRequest == (commandWord[1] && !commandWord[0]))
      else $error("stop or start request wrong");
   AST_LEVELS: assert property ({reverseRequest, rampOutZero, rampHold, rampInZero} ==
      {commandWord[2], commandWord[11], commandWord[12], commandWord[13]})
      else $error("level outputs differ from stored word");
   AST_BUS_BITS: assert property ({busTakeControl, busTakeReference, userBits} ==
      {commandWord[16], commandWord[17], commandWord[25:22]})
      else $error("bus request or user bits differ from stored word");
   AST_CFG_MODE: assert property (!$past(srst) && commandWord[9:7] == 3'h0 |->
      stopMode == $past(cfgStopMode))
      else $error("configured stop mode not used");
   AST_MODE: assert property ((|commandWord[9:7]) |-> stopMode == (commandWord[9] ? STOP_FREEWHEEL :
      commandWord[8] ? STOP_EMERGENCY_DECEL : STOP_NORMAL_DECEL))
      else $error("requested stop mode wrong");
   AST_FAULT: assert property (faultResetPulse |-> commandWord[4] && !$past(commandWord[4]) &&
      $past(faultActive) ##1 !faultResetPulse)
      else $error("fault reset pulse without rising edge");
   AST_FAULT_FIRE: assert property (cmdWr && objWrData[4] && !commandWord[4] && faultActive |->
      ##1 faultResetPulse)
      else $error("rising fault reset bit gave no pulse");
   AST_RUN: assert property (!$past(srst) && $past(cfgRunEnableFromBus) |-> runEnable == !commandWord[6])
      else $error("run enable not from bus bit");
   AST_LOC: assert property (!$past(srst) && $past(cfgLocationFromBus) |->
      externalLocationB == commandWord[5])
      else $error("location not from bus bit");
   AST_READ: assert property (actRd |=> objRdValid && !objError && objRdData[31:16] == 16'h0000)
      else $error("actual value read not answered");
   AST_REFUSE: assert property (objRead && objIndex == IDX_COMMAND_WORD |=> objError && !objRdValid)
      else $error("read of write-only word not refused");
   cover property (cmdWr ##1 faultResetPulse);
   cover property (actRd ##1 objRdValid);
   cover property (objError);
endmodule

bind fdc_command_decoder fdc_command_decoder_sva chk (.clk(clk), .srst(srst), .objWrite(objWrite), .objRead(objRead),
   .objIndex(objIndex), .objWrData(objWrData), .objRdData(objRdData), .objRdValid(objRdValid), .objError(objError),
   .cfgLocationFromBus(cfgLocationFromBus), .cfgRunEnableFromBus(cfgRunEnableFromBus), .cfgStopMode(cfgStopMode),
   .faultActive(faultActive),
   .commandWord(commandWord), .stopRequest(stopRequest), .stopMode(stopMode), .startRequest(startRequest),
   .reverseRequest(reverseRequest), .faultResetPulse(faultResetPulse), .externalLocationB(externalLocationB),
   .runEnable(runEnable), .rampOutZero(rampOutZero), .rampHold(rampHold), .rampInZero(rampInZero),
   .busTakeControl(busTakeControl), .busTakeReference(busTakeReference), .userBits(userBits));

/* File: testbench/fdc_bus_master.sv */
// bus master model that writes and reads drive objects
`timescale 1ns/10ps
module fdc_bus_master
   import fdc_pkg::*;
(
   // clock
   input wire logic clk,
   // object access
   output logic objWrite,
   output logic objRead,
   output logic [fdc_pkg::INDEX_W-1:0] objIndex,
   output logic [fdc_pkg::WORD_W-1:0] objWrData,
   input wire logic [fdc_pkg::WORD_W-1:0] objRdData,
   input wire logic objRdValid,
   input wire logic objError
);
   initial begin
      objWrite = 1'b0;
      objRead = 1'b0;
      objIndex = 16'h0000;
      objWrData = 32'h0000_0000;
   end
   // index inverts after every access and write data after every write, so stale values never look valid
   task automatic wr(input logic [15:0] idx, input logic [31:0] dat);
      @(posedge clk);
      objWrite <= 1'b1;
      objIndex <= idx;
      objWrData <= dat;
      @(posedge clk);
      objWrite <= 1'b0;
      objIndex <= ~idx;
      objWrData <= ~dat;
   endtask
   task automatic rd(input logic [15:0] idx, output logic [31:0] dat, output logic ok, output logic err);
      @(posedge clk);
      objRead <= 1'b1;
      objIndex <= idx;
      @(posedge clk);
      objRead <= 1'b0;
      objIndex <= ~idx;
      #1;
      dat = objRdData;
      ok = objRdValid;
      err = objError;
   endtask
endmodule

/* File: testbench/fieldbus_drive_command_decoder_test.sv */
// self-checking testbench for the drive command decoder
`timescale 1ns/10ps
module fieldbus_drive_command_decoder_test;
   import fdc_pkg::*;
   typedef struct packed {logic [31:0] word; logic [13:0] exp;} fdc_row_s;
   logic clk = 1'b0, srst = 1'b1, objWrite, objRead, objRdValid, objError, faultActive = 1'b0;
   logic cfgLocationFromBus = 1'b0, cfgRunEnableFromBus = 1'b0, otherLocationB = 1'b0, otherRunEnable = 1'b0;
   logic stopRequest, startRequest, reverseRequest, faultResetPulse, externalLocationB, runEnable;
   logic rampOutZero, rampHold, rampInZero, busTakeControl, busTakeReference;
   logic [15:0] objIndex, cfgScale = 16'h0100;
   logic [31:0] objWrData, objRdData, commandWord;
   logic signed [31:0] actualOne = 32'sh0, actualTwo = 32'sh0, referenceOne, referenceTwo;
   logic [3:0] userBits;
   fdc_stop_mode_e cfgStopMode = STOP_EMERGENCY_DECEL, stopMode;
   int err_count = 0, checks = 0;
   // expected: stop start reverse rampOut hold rampIn control reference user[3:0] mode[1:0]
   fdc_row_s rows [9] = '{'{32'h0000_0003, 14'h2001}, '{32'h0000_0002, 14'h1001}, '{32'h0000_0085, 14'h2800},
      '{32'h0000_0101, 14'h2001}, '{32'h0000_0381, 14'h2002}, '{32'h0000_3800, 14'h0701},
      '{32'h0003_0000, 14'h00c1}, '{32'h03c0_0000, 14'h003d}, '{32'hfc3c_c408, 14'h0001}};
   always #4 clk = ~clk;
   fdc_bus_master mst (.clk(clk), .objWrite(objWrite), .objRead(objRead), .objIndex(objIndex), .objWrData(objWrData),
      .objRdData(objRdData), .objRdValid(objRdValid), .objError(objError));
   fdc_command_decoder dut (.clk(clk), .srst(srst), .objWrite(objWrite), .objRead(objRead), .objIndex(objIndex),
      .objWrData(objWrData), .objRdData(objRdData), .objRdValid(objRdValid), .objError(objError),
      .cfgScale(cfgScale), .cfgStopMode(cfgStopMode), .cfgLocationFromBus(cfgLocationFromBus),
      .cfgRunEnableFromBus(cfgRunEnableFromBus), .otherLocationB(otherLocationB), .otherRunEnable(otherRunEnable),
      .faultActive(faultActive), .actualOne(actualOne), .actualTwo(actualTwo), .commandWord(commandWord),
      .stopRequest(stopRequest), .stopMode(stopMode), .startRequest(startRequest), .reverseRequest(reverseRequest),
      .faultResetPulse(faultResetPulse), .externalLocationB(externalLocationB), .runEnable(runEnable),
      .rampOutZero(rampOutZero), .rampHold(rampHold), .rampInZero(rampInZero), .busTakeControl(busTakeControl),
      .busTakeReference(busTakeReference), .userBits(userBits), .referenceOne(referenceOne),
      .referenceTwo(referenceTwo));
   function automatic logic [13:0] seen();
      return {stopRequest, startRequest, reverseRequest, rampOutZero, rampHold, rampInZero, busTakeControl,
         busTakeReference, userBits, stopMode};
   endfunction
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // the whole run needs under a hundred cycles
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      end_of_test();
   end
   // ----------------------------------------------------------------
   // table of command words, then hand-written cases
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic v, e;
      logic [13:0] s;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         mst.wr(IDX_COMMAND_WORD, rows[i].word);
         #1;
         s = seen();
         chk("word", rows[i].word, commandWord);
         chk("run", 32'(rows[i].exp[13:11]), 32'(s[13:11]));
         chk("mode", 32'(rows[i].exp[1:0]), 32'(s[1:0]));
         chk("ramp", 32'(rows[i].exp[10:2]), 32'(s[10:2]));
      end
      @(posedge clk) faultActive <= 1'b1;
      mst.wr(IDX_COMMAND_WORD, 32'h0000_0010);
      #1 chk("pulse", 32'h1, 32'(faultResetPulse));
      @(posedge clk);
      #1 chk("pulse end", 32'h0, 32'(faultResetPulse));
      mst.wr(IDX_COMMAND_WORD, 32'h0000_0010);
      #1 chk("held bit", 32'h0, 32'(faultResetPulse));
      mst.wr(IDX_COMMAND_WORD, 32'h0000_0000);
      @(posedge clk) faultActive <= 1'b0;
      mst.wr(IDX_COMMAND_WORD, 32'h0000_0010);
      #1 chk("no fault", 32'h0, 32'(faultResetPulse));
      @(posedge clk) cfgStopMode <= STOP_FREEWHEEL;
      mst.wr(IDX_COMMAND_WORD, 32'h0000_0001);
      #1 chk("configured mode", 32'(STOP_FREEWHEEL), 32'(stopMode));
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         cfgLocationFromBus <= k[0];
         cfgRunEnableFromBus <= k[1];
         otherLocationB <= k[1];
         otherRunEnable <= k[0];
         for (int b = 0; b < 2; b++) begin
            mst.wr(IDX_COMMAND_WORD, b == 0 ? 32'h0000_0060 : 32'h0000_0000);
            #1 chk("location", 32'(k[0] ? b == 0 : k[1]), 32'(externalLocationB));
            chk("run enable", 32'(k[1] ? b == 1 : k[0]), 32'(runEnable));
         end
      end
      @(posedge clk);
      cfgScale <= 16'h0200;
      actualOne <= 32'sh300;
      actualTwo <= -32'sh80;
      mst.wr(IDX_SHORT_REF_ONE, 32'h1234_0100);
      mst.wr(IDX_SHORT_REF_TWO, 32'h0000_ff00);
      @(posedge clk);
      #1 chk("ref one", 32'h0000_0200, referenceOne);
      chk("ref two", 32'hffff_fe00, referenceTwo);
      mst.rd(IDX_SHORT_ACT_ONE, d, v, e);
      chk("act one", 32'h0000_0600, d);
      chk("act valid", 32'h1, {31'h0, v & ~e});
      mst.rd(IDX_SHORT_ACT_TWO, d, v, e);
      chk("act two", 32'h0000_ff00, d);
      for (int j = 0; j < 3; j++) begin
         mst.rd(j == 0 ? IDX_COMMAND_WORD : j == 1 ? IDX_SHORT_REF_ONE : 16'h2054, d, v, e);
         chk("refused read", 32'h1, {d[30:0], e & ~v});
      end
      mst.wr(IDX_SHORT_ACT_TWO, 32'h0000_1111);
      #1 chk("write read-only", 32'h1, 32'(objError));
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("reset word", 32'h0, commandWord);
      chk("reset outputs", 32'h0, {17'h0, seen(), runEnable});
      @(posedge clk) srst <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("run after reset", 32'h1, 32'(runEnable));
      end_of_test();
   end
endmodule
